// *** design/fpm_pkg.sv ***
// Package for the fan PWM mode controller: widths, counts, states, port structs.
// Assumes a single 100 MHz clock domain and comparator bits arriving asynchronously.
package fpm_pkg;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int PWM_RATE_HZ = 30;
  localparam int RAMP_BITS = 8;
  localparam logic [RAMP_BITS-1:0] RAMP_MAX = 8'hFF;
  // Ramp steps per PWM period; one step every STEP_CYCLES clocks
  localparam int STEP_CYCLES_INT = CLK_HZ / (PWM_RATE_HZ * 256);
  localparam int STEP_BITS = 16;
  localparam logic [STEP_BITS-1:0] STEP_CYCLES = STEP_CYCLES_INT[STEP_BITS-1:0];
  localparam logic [STEP_BITS-1:0] STEP_ZERO = 16'h0000;

  // ----------------------------------------
  // Start-up timer
  // ----------------------------------------
  localparam int KICK_BITS = 6;
  localparam logic [KICK_BITS-1:0] KICKSTART_PERIODS = 6'h20;
  localparam logic [KICK_BITS-1:0] KICK_ZERO = 6'h00;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {FPM_FORCED_OFF, FPM_AUTOOFF, FPM_KICKSTART, FPM_NORMAL} fpm_state_t;

  typedef struct packed {
    logic forced_off;     // control voltage below shutdown level
    logic release_ok;     // control voltage above release level
    logic below_autooff;  // control voltage below auto-off threshold
    logic restart_ok;     // above threshold plus hysteresis
    logic over_full;      // above full-duty threshold
  } fpm_cmp_t;

endpackage

// *** design/fpm_sync.sv ***
// Three-stage synchroniser with agreement filter for one comparator bit.
// Assumes the input is asynchronous to CLK and changes slowly.
`timescale 1ns/100ps
module fpm_sync (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic d,
  output logic q
);
  import fpm_pkg::*;

  logic [SYNC_STAGES-1:0] stage;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      stage <= '0;
    end else begin
      stage <= {stage[SYNC_STAGES-2:0], d};
    end
  end

  // Only stages two and three are compared; stage one feeds stage two alone
  always_ff @(posedge CLK) begin
    if (SRST) begin
      q <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      q <= stage[2];
    end
  end
endmodule // fpm_sync

// *** design/fpm_ctrl.sv ***
// Mode and drive logic of the fan PWM controller, top module.
// Assumes analog comparators deliver single-bit results and a 100 MHz clock.
//
// Function
// - Duty rises linearly with control voltage
// - PWM period is the only time base
// - Start-up holds drive on 32 periods
// - Start-up on power-up and leaving off modes
// - Overheat flag low above full-duty level in kickstart or normal
// - Overheat flag never latches
// - Below auto-off threshold turns fan off
// - Leave auto-off only above hysteresis, kickstart
// - Forced-off stops everything, flag inactive
// - Forced-off resets all state except the input synchronisers
// - Release restarts with kickstart if above hysteresis
// - Release below threshold goes auto-off directly
// - Forced-off takes priority over everything
// - Fan drive is active high
// - Normal loops until an off mode
`timescale 1ns/100ps
module fpm_ctrl (
  input wire logic CLK,
  input wire logic SRST,
  input fpm_pkg::fpm_cmp_t CMP,
  input wire logic [fpm_pkg::RAMP_BITS-1:0] DUTY_CODE,
  output logic FAN_SWITCH_DRIVE,
  output logic OVERHEAT_FLAG_N,
  output fpm_pkg::fpm_state_t MODE,
  output logic [fpm_pkg::KICK_BITS-1:0] KICK_LEFT
);
  import fpm_pkg::*;

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  fpm_cmp_t cmp_s;
  logic [RAMP_BITS-1:0] code_s1;
  logic [RAMP_BITS-1:0] code_s2;
  logic [RAMP_BITS-1:0] code_s3;
  logic [RAMP_BITS-1:0] code_hold;

  fpm_sync u_sync_off (.CLK(CLK), .SRST(SRST), .d(CMP.forced_off), .q(cmp_s.forced_off));
  fpm_sync u_sync_rel (.CLK(CLK), .SRST(SRST), .d(CMP.release_ok), .q(cmp_s.release_ok));
  fpm_sync u_sync_low (.CLK(CLK), .SRST(SRST), .d(CMP.below_autooff), .q(cmp_s.below_autooff));
  fpm_sync u_sync_rst (.CLK(CLK), .SRST(SRST), .d(CMP.restart_ok), .q(cmp_s.restart_ok));
  fpm_sync u_sync_ovr (.CLK(CLK), .SRST(SRST), .d(CMP.over_full), .q(cmp_s.over_full));

  always_ff @(posedge CLK) begin
    if (SRST) begin
      code_s1 <= '0;
      code_s2 <= '0;
      code_s3 <= '0;
    end else begin
      code_s1 <= DUTY_CODE;
      code_s2 <= code_s1;
      code_s3 <= code_s2;
    end
  end

  // ----------------------------------------
  // Ramp time base
  // ----------------------------------------
  logic [STEP_BITS-1:0] step_cnt;
  logic [RAMP_BITS-1:0] ramp;
  logic step_tick;
  logic period_end;
  logic kill;

  assign step_tick = (step_cnt == STEP_CYCLES - 16'h0001);
  assign period_end = step_tick && (ramp == RAMP_MAX);
  assign kill = cmp_s.forced_off;

  always_ff @(posedge CLK) begin
    if (SRST || kill) begin
      step_cnt <= STEP_ZERO;
    end else if (step_tick) begin
      step_cnt <= STEP_ZERO;
    end else begin
      step_cnt <= step_cnt + 16'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST || kill) begin
      ramp <= '0;
    end else if (step_tick) begin
      ramp <= ramp + 8'h01;
    end
  end

  // Code sampled once per period
  // Taken only when stages two and three agree; a code in motion waits a period
  always_ff @(posedge CLK) begin
    if (SRST || kill) begin
      code_hold <= '0;
    end else if (period_end && (code_s2 == code_s3)) begin
      code_hold <= code_s3;
    end
  end

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  fpm_state_t state;
  fpm_state_t next_state;
  logic [KICK_BITS-1:0] kick_cnt;
  logic [KICK_BITS-1:0] next_kick_cnt;

  always_comb begin
    next_state = state;
    next_kick_cnt = kick_cnt;
    case (state)
      FPM_FORCED_OFF: begin
        // Release with restart kicks the fan
        if (cmp_s.release_ok && cmp_s.restart_ok) begin
          next_state = FPM_KICKSTART;
          next_kick_cnt = KICKSTART_PERIODS;
        end else if (cmp_s.release_ok) begin
          next_state = FPM_AUTOOFF;
        end
      end
      FPM_AUTOOFF: begin
        if (cmp_s.restart_ok) begin
          next_state = FPM_KICKSTART;
          next_kick_cnt = KICKSTART_PERIODS;
        end
      end
      FPM_KICKSTART: begin
        // Auto-off ends the kick as well
        if (cmp_s.below_autooff) begin
          next_state = FPM_AUTOOFF;
          next_kick_cnt = KICK_ZERO;
        end else if (period_end) begin
          next_kick_cnt = kick_cnt - 6'h01;
          if (kick_cnt == 6'h01) begin
            next_state = FPM_NORMAL;
          end
        end
      end
      FPM_NORMAL: begin
        if (cmp_s.below_autooff) begin
          next_state = FPM_AUTOOFF;
        end
      end
      default: begin
        next_state = FPM_FORCED_OFF;
        next_kick_cnt = KICK_ZERO;
      end
    endcase
  end

  // Power-up starts in forced-off, then kickstart or auto-off on release
  always_ff @(posedge CLK) begin
    if (SRST || kill) begin
      state <= FPM_FORCED_OFF;
      kick_cnt <= KICK_ZERO;
    end else begin
      state <= next_state;
      kick_cnt <= next_kick_cnt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Ramp runs free and is not restarted at kickstart, so the first kick period can be partial

  always_ff @(posedge CLK) begin
    if (SRST || kill) begin
      FAN_SWITCH_DRIVE <= 1'b0;
    end else begin
      case (next_state)
        FPM_KICKSTART: FAN_SWITCH_DRIVE <= 1'b1;
        FPM_NORMAL: FAN_SWITCH_DRIVE <= cmp_s.over_full || (ramp < code_hold);
        default: FAN_SWITCH_DRIVE <= 1'b0;
      endcase
    end
  end

  // Flag low while above full duty in kickstart or normal
  always_ff @(posedge CLK) begin
    if (SRST || kill) begin
      OVERHEAT_FLAG_N <= 1'b1;
    end else begin
      OVERHEAT_FLAG_N <= !(cmp_s.over_full &&
                           (next_state == FPM_NORMAL || next_state == FPM_KICKSTART));
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST || kill) begin
      MODE <= FPM_FORCED_OFF;
      KICK_LEFT <= KICK_ZERO;
    end else begin
      MODE <= next_state;
      KICK_LEFT <= next_kick_cnt;
    end
  end
endmodule // fpm_ctrl

// *** verification/fpm_sense_model.sv ***
// Sense network model: control level in mV to comparator bits.
// Assumes the bench sets level and threshold.
`timescale 1ns/100ps
module fpm_sense_model #(
  parameter int SHDN_MV = 500,
  parameter int REL_MV = 700,
  parameter int HAS_MV = 70,
  parameter int FULL_MV = 2650
) (
  input wire logic [11:0] level_mv,
  input wire logic [11:0] autooff_threshold,
  output fpm_pkg::fpm_cmp_t cmp
);
  always_comb begin
    cmp.forced_off = level_mv < SHDN_MV;
    cmp.release_ok = level_mv > REL_MV;
    cmp.below_autooff = level_mv < autooff_threshold;
    cmp.restart_ok = level_mv > autooff_threshold + HAS_MV;
    cmp.over_full = level_mv > FULL_MV;
  end
endmodule // fpm_sense_model

// *** verification/fpm_ctrl_monitor.sv ***
// Checker on the ports of the fan mode controller.
// Assumes the bind below; 8 clocks cover the synchroniser.
`timescale 1ns/100ps
module fpm_ctrl_monitor (
  input wire logic CLK,
  input wire logic SRST,
  input fpm_pkg::fpm_cmp_t CMP,
  input wire logic FAN_SWITCH_DRIVE,
  input wire logic OVERHEAT_FLAG_N,
  input fpm_pkg::fpm_state_t MODE,
  input wire logic [fpm_pkg::KICK_BITS-1:0] KICK_LEFT
);
  import fpm_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic off;
  assign off = MODE inside {FPM_FORCED_OFF, FPM_AUTOOFF};
  off_drive_low_a: assert property (off |-> !FAN_SWITCH_DRIVE)
    else $error("drive on while off");
  off_flag_idle_a: assert property (off |-> OVERHEAT_FLAG_N)
    else $error("flag low while off");
  kick_drive_on_a: assert property (MODE == FPM_KICKSTART |-> FAN_SWITCH_DRIVE)
    else $error("drive off in kickstart");
  kick_load_a: assert property (off ##1 MODE == FPM_KICKSTART |->
    KICK_LEFT == KICKSTART_PERIODS)
    else $error("kick count not loaded");
  forced_reset_a: assert property (CMP.forced_off [*8] |->
    MODE == FPM_FORCED_OFF && KICK_LEFT == KICK_ZERO)
    else $error("forced off not reset");
  flag_set_a: assert property ((CMP.over_full && !CMP.below_autooff)[*8]
    ##0 (MODE[1] && $stable(MODE)) |-> !OVERHEAT_FLAG_N)
    else $error("flag not raised");
  flag_clear_a: assert property ((!CMP.over_full)[*8] |-> OVERHEAT_FLAG_N)
    else $error("flag latched");
  autooff_entry_a: assert property ((CMP.release_ok && CMP.below_autooff)[*8]
    |-> MODE == FPM_AUTOOFF)
    else $error("no auto off");
  early_kick_a: assert property ((MODE == FPM_AUTOOFF && !CMP.restart_ok)[*8]
    |=> MODE != FPM_KICKSTART)
    else $error("restart below margin");
  cover property (off ##1 MODE == FPM_KICKSTART);
  cover property (MODE == FPM_KICKSTART ##1 MODE == FPM_AUTOOFF);
  cover property ($fell(OVERHEAT_FLAG_N));
endmodule // fpm_ctrl_monitor
bind fpm_ctrl fpm_ctrl_monitor u_mon (.CLK(CLK), .SRST(SRST), .CMP(CMP),
  .FAN_SWITCH_DRIVE(FAN_SWITCH_DRIVE), .OVERHEAT_FLAG_N(OVERHEAT_FLAG_N),
  .MODE(MODE), .KICK_LEFT(KICK_LEFT));

// *** verification/fpm_ctrl_tb.sv ***
// Self-checking bench for the fan mode controller.
// Assumes the sense model drives CMP; period ends lie beyond the run.
`timescale 1ns/100ps
module fpm_ctrl_tb;
  import fpm_pkg::*;
  logic CLK = 0;
  logic SRST = 1;
  logic [11:0] lvl = 12'h064;
  logic [11:0] thr = 12'h5DC;
  logic [7:0] code = 8'h00;
  fpm_cmp_t cmp;
  logic drv;
  logic flag_n;
  fpm_state_t mode;
  logic [KICK_BITS-1:0] kick;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 82;
  int lv_tab[10] = '{100, 2800, 2000, 1400, 1510, 2000, 100, 1400, 100, 2000};
  int th_tab[10] = '{1500, 1500, 1500, 1500, 1500, 1500, 1500, 1500, 0, 0};
  int v;
  int em = 0;
  int ek = 0;
  fpm_sense_model u_sense (.level_mv(lvl), .autooff_threshold(thr), .cmp(cmp));
  fpm_ctrl dut (.CLK(CLK), .SRST(SRST), .CMP(cmp), .DUTY_CODE(code),
    .FAN_SWITCH_DRIVE(drv), .OVERHEAT_FLAG_N(flag_n), .MODE(mode), .KICK_LEFT(kick));
  initial begin
    forever #5 CLK = ~CLK;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge CLK);
    SRST = 0;
    for (int i = 0; i < 10; i++) begin
      @(negedge CLK);
      v = lv_tab[i] + $unsigned($random(seed)) % 40;
      lvl = 12'(v);
      thr = 12'(th_tab[i]);
      code = 8'($random(seed));
      // Model: off levels win, then auto off, then restart margin
      if (v < 500) begin
        em = 0;
        ek = 0;
      end else if (v < th_tab[i]) begin
        em = 1;
      end else if (em < 2 && v > th_tab[i] + 70) begin
        em = 2;
        ek = 32;
      end else if (em == 0) begin
        em = 1;
      end
      repeat (8) @(negedge CLK);
      for (int k = 0; k < 20 && mode !== 2'(em); k++) @(negedge CLK);
      check(mode, 8'(em));
      check(drv, 8'(em == 2));
      check(flag_n, 8'(!(em == 2 && v > 2650)));
      if (em != 1) check(kick, 8'(ek));
    end
    final_report();
  end
endmodule // fpm_ctrl_tb
